/* logic/conv_cfg_top.sv */
// Top: AHB-Lite slave for converter configuration and analog pin release
//
// Operation
// R1: Bit 7 picks power: 0 high speed, 1 low power.
// R2: Bits 6:5 divide input clock by 1, 2, 4 or 8.
// R3: Bit 4 picks sample time: 0 short, 1 long.
// R4: Bits 3:2 resolution: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// R5: Bits 1:0 source: bus, bus/2, alternate, asynchronous clock.
// R6: First pin register, bit n disables port control of channel n.
// R7: Second pin register, bit n disables port control of channel 8+n.
// R8: Each pin bit goes to its pin's port logic.
// R9: Set bit forces output high-impedance, input off reading zero, pullup off.
// R10: Bus clock selected after reset; async clock runs in wait and stop3.
// R11: Three read/write byte registers, all cleared by reset.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module conv_cfg_top
    import conv_cfg_pkg::*;
#(
    parameter int channels = channel_count
) (
    // Clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter core controls
    output logic low_power_select,
    output logic [1:0] clock_divide_select,
    output logic long_sample_select,
    output logic [1:0] resolution_select,
    output logic [1:0] input_clock_select,
    output logic async_clock_keep_on,
    // Port logic controls per channel
    output logic [channels-1:0] analog_pin_disable,
    output logic [channels-1:0] port_output_hiz,
    output logic [channels-1:0] port_input_off,
    output logic [channels-1:0] port_pullup_off
);
    cfg_regs_if regs();

    cfg_reg_file u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .regs(regs)
    );

    // Address phase capture
    logic wr_pend_q, wr_pend_d;
    logic [1:0] sel_q, sel_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] dec_sel;
    logic dec_hit;
    logic take;
    logic ready_q, ready_d;
    logic resp_q, resp_d;

    always_comb begin
        dec_hit = 1'b1;
        dec_sel = 2'h3;
        case (haddr)
            addr_config: dec_sel = 2'h0;
            addr_pin_lo: dec_sel = 2'h1;
            addr_pin_hi: dec_sel = 2'h2;
            default: dec_hit = 1'b0;
        endcase
    end

    assign take = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);
    assign regs.wr_en = wr_pend_q;
    assign regs.wr_sel = sel_q;
    assign regs.wr_data = hwdata[reg_width-1:0];

    always_comb begin
        wr_pend_d = take && hwrite && dec_hit;
        sel_d = dec_sel;
        rdata_d = 32'h0;
        // Zero wait states, always OKAY
        ready_d = 1'b1;
        resp_d = 1'b0;
        if (take && !hwrite && dec_hit) begin
            case (dec_sel)
                2'h0: rdata_d = {24'h0, regs.config_val}; // see R11
                2'h1: rdata_d = {24'h0, regs.pin_disable[7:0]};
                2'h2: rdata_d = {24'h0, regs.pin_disable[15:8]};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            sel_q <= 2'h0;
            rdata_q <= 32'h0;
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else if (clk_en) begin
            wr_pend_q <= wr_pend_d;
            sel_q <= sel_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            resp_q <= resp_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;

    // Registered decode of the stored fields
    logic [7:0] cfg_q, cfg_d;
    logic [channels-1:0] pin_q, pin_d;
    logic keep_q, keep_d;

    always_comb begin
        cfg_d = regs.config_val;
        keep_d = clk_src_t'(regs.config_val[src_hi:src_lo]) == src_async; // see R10
        pin_d = regs.pin_disable[channels-1:0]; // see R8
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= config_reset; // see R10
            keep_q <= 1'b0;
            pin_q <= '0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
            keep_q <= keep_d;
            pin_q <= pin_d;
        end
    end

    assign low_power_select = cfg_q[low_power_bit]; // see R1
    assign clock_divide_select = cfg_q[div_hi:div_lo]; // see R2
    assign long_sample_select = cfg_q[long_sample_bit]; // see R3
    assign resolution_select = cfg_q[res_hi:res_lo]; // see R4
    assign input_clock_select = cfg_q[src_hi:src_lo]; // see R5
    assign async_clock_keep_on = keep_q;

    genvar ch;
    generate
        for (ch = 0; ch < channels; ch++) begin : g_pin
            assign analog_pin_disable[ch] = pin_q[ch]; // see R8
            assign port_output_hiz[ch] = pin_q[ch]; // see R9
            assign port_input_off[ch] = pin_q[ch];
            assign port_pullup_off[ch] = pin_q[ch];
        end
    endgenerate

    a_low_power_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> low_power_select == $past(regs.config_val[low_power_bit])) // see R1
        else $error("power select does not follow register");
    a_divide_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> clock_divide_select == $past(regs.config_val[div_hi:div_lo])) // see R2
        else $error("divide select does not follow register");
    a_sample_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> long_sample_select == $past(regs.config_val[long_sample_bit])) // see R3
        else $error("sample select does not follow register");
    a_res_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> resolution_select == $past(regs.config_val[res_hi:res_lo])) // see R4
        else $error("resolution does not follow register");
    a_src_write_path: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && hwrite && haddr == addr_config) ##1 clk_en ##1 clk_en
        |=> input_clock_select == $past(hwdata[src_hi:src_lo], 2)) // see R5
        else $error("clock source write not seen three cycles on");
    a_pin_release: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> (port_output_hiz == $past(regs.pin_disable[channels-1:0])
        && port_input_off == port_output_hiz && port_pullup_off == port_output_hiz)) // see R9
        else $error("pin release not forced");
    a_pin_route: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> analog_pin_disable == $past(regs.pin_disable[channels-1:0])) // see R8
        else $error("pin bits not routed");
    a_async_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en |=> async_clock_keep_on == ($past(regs.config_val[src_hi:src_lo]) == src_async)) // see R10
        else $error("async keep-on wrong");
    a_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && haddr == addr_pin_lo) |=> hrdata == {24'h0, $past(regs.pin_disable[7:0])}) // see R6
        else $error("pin register read wrong");

    // Bus response, decode, freeze and clock source checks
    a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout) // see R11
        else $error("wait state inserted");
    a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        !hresp) // see R11
        else $error("error response given");
    a_read_config: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && haddr == addr_config) |=> hrdata == {24'h0, $past(regs.config_val)}) // see R11
        else $error("configuration read wrong");
    a_read_pin_hi: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && haddr == addr_pin_hi) |=> hrdata == {24'h0, $past(regs.pin_disable[15:8])}) // see R7
        else $error("upper pin register read wrong");
    a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && !hwrite && !dec_hit) |=> hrdata == 32'h0) // see R11
        else $error("unmapped read not zero");
    a_unmapped_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && take && hwrite && !dec_hit) |=> !regs.wr_en) // see R11
        else $error("unmapped write reached registers");
    a_idle_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && !take) |=> hrdata == 32'h0) // see R11
        else $error("read data outside data phase");
    a_freeze_regs: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_en |=> ($stable(regs.config_val) && $stable(regs.pin_disable) && $stable(hrdata))) // see R11
        else $error("registers moved while frozen");
    a_freeze_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_en |=> ($stable(analog_pin_disable) && $stable(input_clock_select) && $stable(async_clock_keep_on))) // see R8
        else $error("controls moved while frozen");
    a_reset_source: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> input_clock_select == src_bus) // see R10
        else $error("bus clock not selected after reset");
    a_keep_needs_async: assert property (@(posedge hclk) disable iff (!hresetn)
        async_clock_keep_on |-> input_clock_select == src_async) // see R10
        else $error("keep-on without asynchronous source");
endmodule // conv_cfg_top

/* logic/conv_cfg_pkg.sv */
// Package: register map, field layout and encodings of the converter configuration block
package conv_cfg_pkg;
    // Byte addresses on the register bus
    localparam logic [7:0] addr_config = 8'h00;
    localparam logic [7:0] addr_pin_lo = 8'h04;
    localparam logic [7:0] addr_pin_hi = 8'h08;
    localparam int reg_width = 8;
    localparam int channel_count = 16;
    localparam logic [7:0] config_reset = 8'h00;
    localparam logic [7:0] pin_reset = 8'h00;
    // Configuration field positions
    localparam int low_power_bit = 7;
    localparam int div_hi = 6;
    localparam int div_lo = 5;
    localparam int long_sample_bit = 4;
    localparam int res_hi = 3;
    localparam int res_lo = 2;
    localparam int src_hi = 1;
    localparam int src_lo = 0;
    // AHB encodings
    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq = 2'h3;
    localparam logic [2:0] hsize_word = 3'h2;
    typedef enum logic [1:0] {div_by_1 = 2'h0, div_by_2 = 2'h1, div_by_4 = 2'h2, div_by_8 = 2'h3} clk_div_t;
    typedef enum logic [1:0] {res_8bit = 2'h0, res_12bit = 2'h1, res_10bit = 2'h2, res_reserved = 2'h3} resolution_t;
    typedef enum logic [1:0] {src_bus = 2'h0, src_bus_half = 2'h1, src_alternate = 2'h2, src_async = 2'h3} clk_src_t;
endpackage

/* logic/cfg_regs_if.sv */
// Interface: register write port and stored values between bus slave and register file
`timescale 1ns/1ps
interface cfg_regs_if;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;
    logic [7:0] config_val;
    logic [15:0] pin_disable;
    modport store (input wr_en, wr_sel, wr_data, output config_val, pin_disable);
    modport access (output wr_en, wr_sel, wr_data, input config_val, pin_disable);
endinterface

/* logic/cfg_reg_file.sv */
// Register file: configuration byte and two pin-disable bytes
`timescale 1ns/1ps
module cfg_reg_file
    import conv_cfg_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Register access
    cfg_regs_if.store regs
);
    logic [7:0] config_q, config_d;
    logic [15:0] pin_q, pin_d;

    always_comb begin
        config_d = config_q;
        pin_d = pin_q;
        if (regs.wr_en) begin
            case (regs.wr_sel)
                2'h0: config_d = regs.wr_data;
                2'h1: pin_d[7:0] = regs.wr_data; // see R6
                2'h2: pin_d[15:8] = regs.wr_data; // see R7
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_q <= config_reset; // see R11
            pin_q <= {pin_reset, pin_reset};
        end else if (clk_en) begin
            config_q <= config_d;
            pin_q <= pin_d;
        end
    end

    assign regs.config_val = config_q;
    assign regs.pin_disable = pin_q;

    a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && regs.wr_en && regs.wr_sel == 2'h0) |=> config_q == $past(regs.wr_data)) // see R11
        else $error("configuration write lost");
    a_pin_hi_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && regs.wr_en && regs.wr_sel == 2'h2) |=> pin_q[15:8] == $past(regs.wr_data)) // see R7
        else $error("upper pin byte write lost");
    a_pin_lo_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && regs.wr_en && regs.wr_sel == 2'h1) |=> pin_q[7:0] == $past(regs.wr_data)) // see R6
        else $error("lower pin byte write lost");
endmodule // cfg_reg_file

/* test/port_pin_model.sv */
// Model of the port pin logic that receives the pin-release controls
`timescale 1ns/1ps
module port_pin_model (
    // Controls from the block
    input wire logic [15:0] port_output_hiz,
    input wire logic [15:0] port_input_off,
    input wire logic [15:0] port_pullup_off,
    // Pin side
    input wire logic [15:0] port_drive,
    input wire logic [15:0] analog_level,
    output logic [15:0] pin_level,
    output logic [15:0] port_read
);
    // Released pin follows the analog source; a pullup left on would pull it high
    assign pin_level = (port_output_hiz & (analog_level | ~port_pullup_off)) | (~port_output_hiz & port_drive);
    // Disabled input buffer reads zero
    assign port_read = pin_level & ~port_input_off;
endmodule // port_pin_model

/* test/tb_adc_config_and_pin_control.sv */
// Testbench: register access, field decode and pin release of the configuration block
`timescale 1ns/1ps
module tb_adc_config_and_pin_control;
    import conv_cfg_pkg::*;
    logic hclk, hresetn, clk_en, hsel, hwrite;
    logic [7:0] haddr, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic hready, hreadyout, hresp, lp, ls, keep;
    logic [1:0] dv, res, src;
    logic [15:0] apd, hiz, inoff, puoff, pin_level, port_read;
    int err_count, samples_checked;
    assign hready = hreadyout;
    conv_cfg_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .low_power_select(lp), .clock_divide_select(dv),
        .long_sample_select(ls), .resolution_select(res), .input_clock_select(src), .async_clock_keep_on(keep),
        .analog_pin_disable(apd), .port_output_hiz(hiz), .port_input_off(inoff), .port_pullup_off(puoff));
    port_pin_model pins (.port_output_hiz(hiz), .port_input_off(inoff), .port_pullup_off(puoff),
        .port_drive(16'hffff), .analog_level(16'h0000), .pin_level(pin_level), .port_read(port_read));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= htrans_nonseq;
        hsize <= hsize_word;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        check(hresp, 1'b0);
    endtask
    task automatic settle();
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        hclk = 0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        hresetn = 0; clk_en = 1; hsel = 1; hwrite = 0; haddr = 0; htrans = 0; hsize = 0; hwdata = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        for (int a = 0; a < 3; a++) begin
            bus(0, 8'(a * 4), 0, rd);
            check(rd, 32'h0);
        end
        check(src, 2'h0);
        // Every code of every field, reserved resolution included
        for (int i = 0; i < 4; i++) begin
            v = {i[0], i[1:0], i[0], i[1:0], i[1:0]};
            bus(1, addr_config, {24'hffffff, v}, rd);
            bus(0, addr_config, 0, rd);
            check(rd, {24'h0, v});
            settle();
            check(lp, v[7]);
            check(dv, v[6:5]);
            check(ls, v[4]);
            check(res, v[3:2]);
            check(src, v[1:0]);
            check(keep, v[1:0] == 2'h3);
        end
        bus(1, addr_pin_lo, 32'hffffffa5, rd);
        bus(1, addr_pin_hi, 32'h0000003c, rd);
        bus(0, addr_pin_lo, 0, rd);
        check(rd, 32'ha5);
        bus(0, addr_pin_hi, 0, rd);
        check(rd, 32'h3c);
        settle();
        check(apd, 16'h3ca5);
        check(hiz, 16'h3ca5);
        check(inoff, 16'h3ca5);
        check(puoff, 16'h3ca5);
        check(port_read, 16'hc35a);
        check(pin_level, 16'hc35a);
        // Unmapped place and a frozen bus
        bus(1, 8'h0c, 32'h000000ff, rd);
        bus(0, 8'h0c, 0, rd);
        check(rd, 32'h0);
        clk_en <= 0;
        bus(1, addr_config, 0, rd);
        clk_en <= 1;
        bus(0, addr_config, 0, rd);
        check(rd, 32'hff);
        hresetn <= 0;
        settle();
        check({lp, dv, ls, res, src}, 8'h00);
        check(apd, 16'h0);
        check(keep, 1'b0);
        @(posedge hclk);
        hresetn <= 1;
        bus(0, addr_pin_hi, 0, rd);
        check(rd, 32'h0);
        tally_and_finish();
    end
endmodule // tb_adc_config_and_pin_control
